/* inc/ctw_defs.svh */
// Opcode, flag position and cycle-count constants for the test/transfer/wait decoder
`ifndef CTW_DEFS_SVH
`define CTW_DEFS_SVH
`define CTW_OP_TEST_DIR  8'h3d
`define CTW_OP_TEST_ACC  8'h4d
`define CTW_OP_TEST_IDX  8'h5d
`define CTW_OP_TEST_OFF  8'h6d
`define CTW_OP_TEST_PTR  8'h7d
`define CTW_OP_XFER      8'h9f
`define CTW_OP_WAIT      8'h8f
`define CTW_OP_STOP      8'h8e
`define CTW_CYC_TEST_DIR 4'h4
`define CTW_CYC_TEST_ACC 4'h3
`define CTW_CYC_TEST_IDX 4'h3
`define CTW_CYC_TEST_OFF 4'h5
`define CTW_CYC_TEST_PTR 4'h4
`define CTW_CYC_XFER     4'h2
`define CTW_CYC_WAIT     4'h2
`define CTW_CYC_STOP     4'h2
`define CTW_CYC_BRBIT    4'h5
`define CTW_CYC_DEFAULT  4'h2
`define CTW_FLAG_C       0
`define CTW_FLAG_Z       1
`define CTW_FLAG_N       2
`define CTW_FLAG_I       3
`define CTW_FLAG_H       4
`define CTW_FLAGS_RESET  8'he8
`endif

/* inc/ctw_pkg.sv */
// Types shared by the test/transfer/wait decoder
package ctw_pkg;
    typedef enum logic [2:0] {
        AM_INHERENT  = 3'h0,
        AM_IMMEDIATE = 3'h1,
        AM_DIRECT    = 3'h2,
        AM_EXTENDED  = 3'h3,
        AM_IDX_LONG  = 3'h4,
        AM_IDX_SHORT = 3'h5,
        AM_IDX_PLAIN = 3'h6,
        AM_BITBRANCH = 3'h7
    } ctw_mode_e;

    typedef struct packed {
        ctw_mode_e  mode;
        logic [1:0] operand_bytes;
        logic [3:0] cycles;
        logic       is_test;
        logic       test_accum;
        logic       test_index;
        logic       is_transfer;
        logic       is_wait;
        logic       is_stop;
        logic [3:0] alu_op;
    } ctw_decode_s;

    typedef struct packed {
        logic [15:0] addr;
        logic        addr_valid;
        logic [7:0]  rel_offset;
        logic        rel_valid;
    } ctw_addr_s;
endpackage : ctw_pkg

/* rtl/ctw_decode_rom.sv */
// Combinational opcode classifier for the test/transfer/wait decoder
`timescale 1ns/100ps
`include "ctw_defs.svh"
module ctw_decode_rom (
    // Opcode in
    input  wire logic [7:0]          opcode_i,
    // Decoded fields out
    output ctw_pkg::ctw_decode_s     dec_o
);
    always_comb begin
        dec_o               = '0;
        dec_o.mode          = ctw_pkg::AM_INHERENT;
        dec_o.cycles        = `CTW_CYC_DEFAULT;
        dec_o.alu_op        = opcode_i[3:0];
        case (opcode_i[7:4])
            4'ha: begin
                dec_o.mode          = ctw_pkg::AM_IMMEDIATE;
                dec_o.operand_bytes = 2'h1;
            end
            4'hb: begin
                dec_o.mode          = ctw_pkg::AM_DIRECT;
                dec_o.operand_bytes = 2'h1;
            end
            4'hc: begin
                dec_o.mode          = ctw_pkg::AM_EXTENDED;
                dec_o.operand_bytes = 2'h2;
            end
            4'hd: begin
                dec_o.mode          = ctw_pkg::AM_IDX_LONG;
                dec_o.operand_bytes = 2'h2;
            end
            4'he: begin
                dec_o.mode          = ctw_pkg::AM_IDX_SHORT;
                dec_o.operand_bytes = 2'h1;
            end
            4'hf: begin
                dec_o.mode          = ctw_pkg::AM_IDX_PLAIN;
                dec_o.operand_bytes = 2'h0;
            end
            4'h0: begin
                dec_o.mode          = ctw_pkg::AM_BITBRANCH;
                dec_o.operand_bytes = 2'h2;
                dec_o.cycles        = `CTW_CYC_BRBIT;
            end
            default: ;
        endcase
        case (opcode_i)
            `CTW_OP_TEST_DIR: begin
                dec_o.is_test       = 1'b1;
                dec_o.mode          = ctw_pkg::AM_DIRECT;
                dec_o.operand_bytes = 2'h1;
                dec_o.cycles        = `CTW_CYC_TEST_DIR;
            end
            `CTW_OP_TEST_ACC: begin
                dec_o.is_test       = 1'b1;
                dec_o.test_accum    = 1'b1;
                dec_o.cycles        = `CTW_CYC_TEST_ACC;
            end
            `CTW_OP_TEST_IDX: begin
                dec_o.is_test       = 1'b1;
                dec_o.test_index    = 1'b1;
                dec_o.cycles        = `CTW_CYC_TEST_IDX;
            end
            `CTW_OP_TEST_OFF: begin
                dec_o.is_test       = 1'b1;
                dec_o.mode          = ctw_pkg::AM_IDX_SHORT;
                dec_o.operand_bytes = 2'h1;
                dec_o.cycles        = `CTW_CYC_TEST_OFF;
            end
            `CTW_OP_TEST_PTR: begin
                dec_o.is_test       = 1'b1;
                dec_o.mode          = ctw_pkg::AM_IDX_PLAIN;
                dec_o.cycles        = `CTW_CYC_TEST_PTR;
            end
            `CTW_OP_XFER: begin
                dec_o.is_transfer   = 1'b1;
                dec_o.cycles        = `CTW_CYC_XFER;
            end
            `CTW_OP_WAIT: begin
                dec_o.is_wait       = 1'b1;
                dec_o.cycles        = `CTW_CYC_WAIT;
            end
            `CTW_OP_STOP: begin
                dec_o.is_stop       = 1'b1;
                dec_o.cycles        = `CTW_CYC_STOP;
            end
            default: ;
        endcase
    end
endmodule : ctw_decode_rom

/* rtl/ctw_decoder.sv */
// Test/transfer/wait instruction decoder with operand fetch and flag update
//
// Functional notes
// - Test sets N, Z only; no writeback
// - Test opcodes 3D-7D with listed cycle counts
// - 9F copies index to accumulator, 2 cycles
// - 8F halts CPU clock, clears I
// - Long indexed: high then low, plus index
// - Extended: address high byte then low
// - Short indexed: one offset byte plus index
// - Plain indexed: index is address, no bytes
// - Bit branch: direct byte, then relative offset
// - 8E halts oscillator, clears I
`timescale 1ns/100ps
`include "ctw_defs.svh"
module ctw_decoder (
    // Clock and reset
    input  wire logic                 CLK_I,
    input  wire logic                 RST_I,
    input  wire logic                 CE_I,
    // Fetch stream
    input  wire logic                 FETCH_VALID_I,
    input  wire logic [7:0]           FETCH_BYTE_I,
    output logic                      FETCH_READY_O,
    // CPU register state
    input  wire logic [7:0]           INDEX_I,
    input  wire logic [7:0]           ACCUM_I,
    input  wire logic [7:0]           MEM_DATA_I,
    input  wire logic                 WAKE_I,
    // Decode results
    output ctw_pkg::ctw_decode_s      DEC_O,
    output ctw_pkg::ctw_addr_s        ADDR_O,
    output logic                      DONE_O,
    // State outputs
    output logic [7:0]                ACCUM_O,
    output logic                      ACCUM_WE_O,
    output logic [7:0]                FLAGS_O,
    output logic                      CPU_CLK_HALT_O,
    output logic                      OSC_HALT_O
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_OPCODE = 3'b000,
        ST_BYTE1  = 3'b001,
        ST_BYTE2  = 3'b011,
        ST_EXEC   = 3'b010,
        ST_HALT   = 3'b110
    } ctw_state_e;

    ctw_state_e            state_q, state_d;
    ctw_pkg::ctw_decode_s  dec_q, dec_d, rom_dec;
    ctw_pkg::ctw_addr_s    addr_q, addr_d;
    logic [7:0]            hi_q, hi_d;
    logic [3:0]            cyc_q, cyc_d;
    logic [7:0]            flags_q, flags_d;
    logic [7:0]            accum_q, accum_d;
    logic                  we_q, we_d;
    logic                  done_q, done_d;
    logic                  chalt_q, chalt_d;
    logic                  ohalt_q, ohalt_d;
    logic [7:0]            test_val;

    ctw_decode_rom ctw_decode_rom_inst (
        .opcode_i (FETCH_BYTE_I),
        .dec_o    (rom_dec)
    );

    // Index plus unsigned offset; shared by both offset modes
    function automatic logic [15:0] idx_add(input logic [15:0] off, input logic [7:0] idx);
        idx_add = off + {8'h00, idx};
    endfunction : idx_add

    assign FETCH_READY_O = (state_q == ST_OPCODE) || (state_q == ST_BYTE1)
                         || (state_q == ST_BYTE2);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_d  = state_q;
        dec_d    = dec_q;
        addr_d   = addr_q;
        hi_d     = hi_q;
        cyc_d    = cyc_q;
        flags_d  = flags_q;
        accum_d  = accum_q;
        we_d     = 1'b0;
        done_d   = 1'b0;
        chalt_d  = chalt_q;
        ohalt_d  = ohalt_q;
        test_val = dec_q.test_accum ? ACCUM_I : (dec_q.test_index ? INDEX_I : MEM_DATA_I);
        case (state_q)
            ST_OPCODE: begin
                if (FETCH_VALID_I) begin
                    dec_d  = rom_dec;
                    addr_d = '0;
                    cyc_d  = rom_dec.cycles - 4'h1;
                    if (rom_dec.mode == ctw_pkg::AM_IDX_PLAIN) begin
                        addr_d.addr       = {8'h00, INDEX_I};
                        addr_d.addr_valid = 1'b1;
                    end
                    state_d = (rom_dec.operand_bytes != 2'h0) ? ST_BYTE1 : ST_EXEC;
                end
            end
            ST_BYTE1: begin
                if (FETCH_VALID_I) begin
                    cyc_d = (cyc_q != 4'h0) ? cyc_q - 4'h1 : 4'h0;
                    case (dec_q.mode)
                        ctw_pkg::AM_IDX_SHORT: begin
                            addr_d.addr       = idx_add({8'h00, FETCH_BYTE_I}, INDEX_I);
                            addr_d.addr_valid = 1'b1;
                            state_d           = ST_EXEC;
                        end
                        ctw_pkg::AM_DIRECT, ctw_pkg::AM_IMMEDIATE: begin
                            addr_d.addr       = {8'h00, FETCH_BYTE_I};
                            addr_d.addr_valid = 1'b1;
                            state_d           = ST_EXEC;
                        end
                        ctw_pkg::AM_BITBRANCH: begin
                            addr_d.addr       = {8'h00, FETCH_BYTE_I};
                            addr_d.addr_valid = 1'b1;
                            state_d           = ST_BYTE2;
                        end
                        default: begin
                            hi_d    = FETCH_BYTE_I;
                            state_d = ST_BYTE2;
                        end
                    endcase
                end
            end
            ST_BYTE2: begin
                if (FETCH_VALID_I) begin
                    cyc_d   = (cyc_q != 4'h0) ? cyc_q - 4'h1 : 4'h0;
                    state_d = ST_EXEC;
                    case (dec_q.mode)
                        ctw_pkg::AM_BITBRANCH: begin
                            addr_d.rel_offset = FETCH_BYTE_I;
                            addr_d.rel_valid  = 1'b1;
                        end
                        ctw_pkg::AM_IDX_LONG: begin
                            addr_d.addr       = idx_add({hi_q, FETCH_BYTE_I}, INDEX_I);
                            addr_d.addr_valid = 1'b1;
                        end
                        default: begin
                            addr_d.addr       = {hi_q, FETCH_BYTE_I};
                            addr_d.addr_valid = 1'b1;
                        end
                    endcase
                end
            end
            ST_EXEC: begin
                if (cyc_q > 4'h1) begin
                    cyc_d = cyc_q - 4'h1;
                end else begin
                    done_d  = 1'b1;
                    state_d = ST_OPCODE;
                    if (dec_q.is_test) begin
                        flags_d[`CTW_FLAG_N] = test_val[7];
                        flags_d[`CTW_FLAG_Z] = (test_val == 8'h00);
                    end
                    if (dec_q.is_transfer) begin
                        accum_d = INDEX_I;
                        we_d    = 1'b1;
                    end
                    if (dec_q.is_wait || dec_q.is_stop) begin
                        flags_d[`CTW_FLAG_I] = 1'b0;
                        chalt_d = dec_q.is_wait;
                        ohalt_d = dec_q.is_stop;
                        state_d = ST_HALT;
                    end
                end
            end
            ST_HALT: begin
                // Only an interrupt request (WAKE_I) or reset releases the core
                if (WAKE_I) begin
                    chalt_d = 1'b0;
                    ohalt_d = 1'b0;
                    state_d = ST_OPCODE;
                end
            end
            default: state_d = ST_OPCODE;
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            state_q <= ST_OPCODE;
            dec_q   <= '0;
            addr_q  <= '0;
            hi_q    <= 8'h00;
            cyc_q   <= 4'h0;
            flags_q <= `CTW_FLAGS_RESET;
            accum_q <= 8'h00;
            we_q    <= 1'b0;
            done_q  <= 1'b0;
            chalt_q <= 1'b0;
            ohalt_q <= 1'b0;
        end else if (CE_I) begin
            state_q <= state_d;
            dec_q   <= dec_d;
            addr_q  <= addr_d;
            hi_q    <= hi_d;
            cyc_q   <= cyc_d;
            flags_q <= flags_d;
            accum_q <= accum_d;
            we_q    <= we_d;
            done_q  <= done_d;
            chalt_q <= chalt_d;
            ohalt_q <= ohalt_d;
        end
    end

    assign DEC_O          = dec_q;
    assign ADDR_O         = addr_q;
    assign DONE_O         = done_q;
    assign ACCUM_O        = accum_q;
    assign ACCUM_WE_O     = we_q;
    assign FLAGS_O        = flags_q;
    assign CPU_CLK_HALT_O = chalt_q;
    assign OSC_HALT_O     = ohalt_q;
endmodule : ctw_decoder

/* bench/ctw_decoder_checker.sv */
// Assertion checker for the test/transfer/wait decoder
`timescale 1ns/100ps
module ctw_decoder_checker (
    // Clock, reset and fetch
    input wire logic                 CLK_I,
    input wire logic                 RST_I,
    input wire logic                 CE_I,
    input wire logic                 FETCH_VALID_I,
    input wire logic [7:0]           FETCH_BYTE_I,
    input wire logic                 FETCH_READY_O,
    // Results
    input wire ctw_pkg::ctw_decode_s DEC_O,
    input wire ctw_pkg::ctw_addr_s   ADDR_O,
    input wire logic                 DONE_O,
    input wire logic                 ACCUM_WE_O,
    input wire logic [7:0]           FLAGS_O,
    input wire logic                 CPU_CLK_HALT_O,
    input wire logic                 OSC_HALT_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    // ----------------
    // Opcode tracking
    // ----------------
    logic op_q;
    logic op_d;
    wire logic take     = CE_I && FETCH_VALID_I && FETCH_READY_O;
    wire logic op_first = op_q || DONE_O;
    wire logic op_take  = take && op_first;
    // Operand bytes may equal opcodes, so only the first byte counts;
    // an opcode may already be taken in the cycle that shows done
    always_comb op_d = RST_I || (op_first && !take);
    always_ff @(posedge CLK_I) op_q <= op_d;
    // ----------------
    // Assertions
    // ----------------
    chk_xfer_timing: assert property (op_take && FETCH_BYTE_I == 8'h9f |->
        ##1 !DONE_O ##1 DONE_O && ACCUM_WE_O) else $error("transfer timing wrong");
    chk_xfer_flags: assert property (ACCUM_WE_O |-> $stable(FLAGS_O))
        else $error("transfer changed flags");
    chk_test_cycles: assert property (op_take && FETCH_BYTE_I == 8'h4d |->
        ##1 !DONE_O [*2] ##1 DONE_O) else $error("test timing wrong");
    chk_test_keep: assert property (DONE_O && DEC_O.is_test |-> !ACCUM_WE_O &&
        FLAGS_O[4:3] == $past(FLAGS_O[4:3]) && FLAGS_O[0] == $past(FLAGS_O[0]))
        else $error("test touched other state");
    chk_dir_addr: assert property (op_take && FETCH_BYTE_I == 8'h3d ##1 take |=>
        ADDR_O.addr_valid && ADDR_O.addr == {8'h00, $past(FETCH_BYTE_I)})
        else $error("direct address wrong");
    chk_wait_done: assert property (op_take && FETCH_BYTE_I == 8'h8f |->
        ##2 DONE_O ##1 !FLAGS_O[3]) else $error("wait timing wrong");
    chk_wait_mask: assert property ($rose(CPU_CLK_HALT_O) |-> !FLAGS_O[3] && DEC_O.is_wait)
        else $error("wait halted with mask set");
    chk_stop_mask: assert property ($rose(OSC_HALT_O) |-> !FLAGS_O[3] && DEC_O.is_stop)
        else $error("stop halted with mask set");
    chk_halt_refuse: assert property (CPU_CLK_HALT_O || OSC_HALT_O |-> !FETCH_READY_O)
        else $error("fetch open while halted");
    cov_xfer: cover property (op_take && FETCH_BYTE_I == 8'h9f);
    cov_test: cover property (DONE_O && DEC_O.is_test);
    cov_wait: cover property ($rose(CPU_CLK_HALT_O));
    cov_stop: cover property ($rose(OSC_HALT_O));
endmodule : ctw_decoder_checker

bind ctw_decoder ctw_decoder_checker ctw_decoder_checker_inst (.CLK_I, .RST_I, .CE_I,
    .FETCH_VALID_I, .FETCH_BYTE_I, .FETCH_READY_O, .DEC_O, .ADDR_O, .DONE_O, .ACCUM_WE_O,
    .FLAGS_O, .CPU_CLK_HALT_O, .OSC_HALT_O);

/* bench/test_cpu_test_transfer_wait_decode.sv */
// Self-checking bench for the test/transfer/wait decoder
`timescale 1ns/100ps
`define CHK(nm, ex, ac) begin n_tests++; if ((ac) !== (ex)) begin n_mismatch++; \
    $display("unexpected %s exp %h got %h", nm, ex, ac); end end
module test_cpu_test_transfer_wait_decode;
    logic       CLK_I = 1'b0, RST_I = 1'b1, CE_I = 1'b1, FETCH_VALID_I = 1'b0, WAKE_I = 1'b0;
    logic [7:0] FETCH_BYTE_I = 8'h00, INDEX_I = 8'h5a, ACCUM_I = 8'h80, MEM_DATA_I = 8'h00;
    logic       FETCH_READY_O, DONE_O, ACCUM_WE_O, CPU_CLK_HALT_O, OSC_HALT_O;
    logic [7:0] ACCUM_O, FLAGS_O, acc_n;
    logic       rdy_n, done_n, we_n;
    int         n_mismatch = 0, n_tests = 0, k;
    ctw_pkg::ctw_decode_s DEC_O;
    ctw_pkg::ctw_addr_s   ADDR_O;
    ctw_decoder ctw_decoder_inst (.CLK_I, .RST_I, .CE_I, .FETCH_VALID_I, .FETCH_BYTE_I,
        .FETCH_READY_O, .INDEX_I, .ACCUM_I, .MEM_DATA_I, .WAKE_I, .DEC_O, .ADDR_O, .DONE_O,
        .ACCUM_O, .ACCUM_WE_O, .FLAGS_O, .CPU_CLK_HALT_O, .OSC_HALT_O);
    initial forever #5 CLK_I = ~CLK_I;
    // Mid-cycle copies avoid racing the design's own edge updates
    always @(negedge CLK_I) begin
        rdy_n = FETCH_READY_O;
        done_n = DONE_O;
        if (DONE_O) begin
            we_n = ACCUM_WE_O;
            acc_n = ACCUM_O;
        end
    end
    // ----------------
    // Shared tasks
    // ----------------
    task automatic do_reset;
        RST_I <= 1'b1;
        repeat (16) @(posedge CLK_I);
        RST_I <= 1'b0;
        @(negedge CLK_I);
        `CHK("reset flags", 8'he8, FLAGS_O)
        `CHK("reset ready", 1'b1, FETCH_READY_O)
    endtask : do_reset
    // Count edges from opcode take to the edge that samples done
    task automatic run(input logic [7:0] op, b1, b2, mem, input int nb);
        logic [7:0] q [3];
        int i;
        q = '{op, b1, b2};
        i = 0;
        k = -1;
        @(posedge CLK_I);
        MEM_DATA_I <= mem;
        FETCH_VALID_I <= 1'b1;
        FETCH_BYTE_I <= op;
        while (!done_n) begin
            @(posedge CLK_I);
            if (k >= 0) k++;
            if (i <= nb && rdy_n) begin
                if (i == 0) k = 0;
                i++;
                if (i <= nb) FETCH_BYTE_I <= q[i];
                else FETCH_VALID_I <= 1'b0;
            end
        end
        @(negedge CLK_I);
    endtask : run
    // ----------------
    // Scenarios
    // ----------------
    task automatic t_xfer;
        run(8'h9f, 8'h00, 8'h00, 8'h00, 0);
        `CHK("xfer cycles", 2, k)
        `CHK("xfer write", 1'b1, we_n)
        `CHK("xfer data", 8'h5a, acc_n)
        `CHK("xfer flags", 8'he8, FLAGS_O)
        $display("transfer test ended");
    endtask : t_xfer
    task automatic t_test;
        logic [7:0]  ops [5] = '{8'h3d, 8'h4d, 8'h5d, 8'h6d, 8'h7d};
        logic [7:0]  val [5] = '{8'h80, 8'h80, 8'h5a, 8'h00, 8'h7f};
        logic [15:0] ad [5] = '{16'h0044, 16'h0, 16'h0, 16'h0152, 16'h005a};
        int          nbs [5] = '{1, 0, 0, 1, 0};
        int          cyc [5] = '{4, 3, 3, 5, 4};
        for (int j = 0; j < 5; j++) begin
            run(ops[j], j == 0 ? 8'h44 : 8'hf8, 8'h00, val[j], nbs[j]);
            `CHK("test cycles", cyc[j], k)
            `CHK("test nz", {val[j][7], val[j] == 8'h00}, FLAGS_O[2:1])
            `CHK("test hic", 8'h08, FLAGS_O & 8'h19)
            `CHK("test write", 1'b0, we_n)
            if (j != 1 && j != 2) `CHK("test addr", ad[j], ADDR_O.addr)
        end
        $display("test family ended");
    endtask : t_test
    task automatic t_mode;
        ctw_pkg::ctw_mode_e md [6] = '{ctw_pkg::AM_IMMEDIATE, ctw_pkg::AM_DIRECT,
            ctw_pkg::AM_EXTENDED, ctw_pkg::AM_IDX_LONG, ctw_pkg::AM_IDX_SHORT,
            ctw_pkg::AM_IDX_PLAIN};
        int nbs [6] = '{1, 1, 2, 2, 1, 0};
        for (int j = 0; j < 6; j++) begin
            run({4'(j + 10), 4'h6}, 8'h12, 8'h34, 8'h00, nbs[j]);
            `CHK("mode", md[j], DEC_O.mode)
            `CHK("byte count", 2'(nbs[j]), DEC_O.operand_bytes)
            if (j == 2) `CHK("ext addr", 16'h1234, ADDR_O.addr)
            if (j == 3) `CHK("long addr", 16'h128e, ADDR_O.addr)
            if (j == 4) `CHK("short addr", 16'h006c, ADDR_O.addr)
            if (j == 5) `CHK("plain addr", 16'h005a, ADDR_O.addr)
            `CHK("alu op", 4'h6, DEC_O.alu_op)
        end
        $display("mode test ended");
    endtask : t_mode
    task automatic t_bit;
        run(8'h00, 8'h55, 8'hfe, 8'h00, 2);
        `CHK("bit cycles", 5, k)
        `CHK("bit addr", 16'h0055, ADDR_O.addr)
        `CHK("bit offset", 8'hfe, ADDR_O.rel_offset)
        `CHK("bit offset valid", 1'b1, ADDR_O.rel_valid)
        `CHK("bit mode", ctw_pkg::AM_BITBRANCH, DEC_O.mode)
        $display("bit branch test ended");
    endtask : t_bit
    task automatic t_halt(input logic [7:0] op);
        run(op, 8'h00, 8'h00, 8'h00, 0);
        repeat (3) @(negedge CLK_I);
        `CHK("halt cycles", 2, k)
        `CHK("halt mask", 1'b0, FLAGS_O[3])
        `CHK("halt kind", {op[0], !op[0]}, {CPU_CLK_HALT_O, OSC_HALT_O})
        `CHK("halt refuse", 1'b0, FETCH_READY_O)
        // Wake must wait while the clock enable holds everything still
        @(posedge CLK_I);
        CE_I <= 1'b0;
        WAKE_I <= 1'b1;
        repeat (3) @(posedge CLK_I);
        @(negedge CLK_I);
        `CHK("halt frozen", 1'b1, CPU_CLK_HALT_O || OSC_HALT_O)
        @(posedge CLK_I);
        CE_I <= 1'b1;
        k = 0;
        while ((CPU_CLK_HALT_O || OSC_HALT_O) && k < 20) begin
            @(negedge CLK_I);
            k++;
        end
        @(posedge CLK_I);
        WAKE_I <= 1'b0;
        `CHK("halt wake", 1'b1, k < 20)
        $display("halt test ended");
    endtask : t_halt
    // ----------------
    // Verdict
    // ----------------
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    // Whole run is far below this span
    initial begin
        #100000;
        n_mismatch++;
        test_done;
    end
    initial begin
        do_reset;
        t_xfer;
        t_test;
        t_mode;
        t_bit;
        t_halt(8'h8f);
        do_reset;
        t_halt(8'h8e);
        test_done;
    end
endmodule : test_cpu_test_transfer_wait_decode
